// ### core/fbwp_defs.svh
// Purpose: constants for the flash block write protect block
// Assumes: included by its bare name
// Notes: offsets are byte addresses on the register bus
`ifndef FBWP_DEFS_SVH
`define FBWP_DEFS_SVH
`define FBWP_OFF_STATUS 8'h00
`define FBWP_OFF_CMD 8'h04
`define FBWP_OFF_ADDR 8'h08
`define FBWP_OFF_RESULT 8'h0c
`define FBWP_OFF_CONFIG 8'h10
`define FBWP_OFF_VOLREG 8'h14
// status byte fields
`define FBWP_ST_WEL 1
`define FBWP_ST_BP_LO 2
`define FBWP_ST_QE 6
`define FBWP_ST_LOCK 7
`define FBWP_STATUS_RST 8'h00
// command opcodes
`define FBWP_OP_WRITE_ENABLE_CMD 8'h06
`define FBWP_OP_WRDI 8'h04
`define FBWP_OP_STATUS_WRITE_CMD 8'h01
`define FBWP_OP_PP 8'h02
`define FBWP_OP_SER 8'h20
`define FBWP_OP_BER 8'hd8
`define FBWP_OP_CER1 8'hc7
`define FBWP_OP_CER2 8'h60
`define FBWP_OP_VOLATILE_READ_PARAM_WRITE_CMD 8'hc0
`define FBWP_OP_VOLATILE_BANK_WRITE_CMD 8'h17
// address bit at which the block index starts
`define FBWP_BLK64_LSB 16
`define FBWP_BLK256_LSB 18
`endif

// ### core/fbwp_pkg.sv
// Purpose: types for the flash block write protect block
// Assumes: nothing
// Notes: states of the command engine
package fbwp_pkg;
  typedef enum logic [1:0] {FBWP_IDLE, FBWP_DATA, FBWP_RESP} fbwp_state_t;
  typedef struct packed {
    logic [7:0] status_sr;
    logic top_bottom_select;
    logic big_blocks;
    logic [7:0] cmd;
    logic [25:0] addr;
    logic [7:0] volreg0;
    logic [7:0] volreg1;
    logic [2:0] result;
    logic [4:0] haddr;
    logic hwrite;
    fbwp_state_t state;
    logic [31:0] hrdata;
  } fbwp_regs_t;
endpackage

// ### core/fbwp_range.sv
// Purpose: decides whether a block index falls in the protected range
// Assumes: block index already derived from the address
// Notes: purely combinational, one instance per check
`timescale 1ns/1ps
module fbwp_range
  import fbwp_pkg::*;
#(
  parameter int IDX_W = 10
) (
  input wire logic [3:0] level,
  input wire logic top_bottom_select,
  input wire logic big_blocks,
  input wire logic [IDX_W-1:0] blk_idx,
  output logic hit
);
  logic [IDX_W:0] count;
  logic [IDX_W-1:0] last;
  always_comb begin
    count = '0;
    if (level != 4'h0 && level < 4'hb)
      count = (IDX_W+1)'(1) << (level - 4'h1);
    unique case (level)
      4'hb: count = (IDX_W+1)'(768);
      4'hc: count = (IDX_W+1)'(896);
      4'hd: count = (IDX_W+1)'(960);
      4'he: count = (IDX_W+1)'(992);
      4'hf: count = (IDX_W+1)'(1024);
      default: ;
    endcase
    if (big_blocks) begin
      if (level == 4'h0)
        count = '0;
      else if (level < 4'h9)
        count = (IDX_W+1)'(1) << (level - 4'h1);
      else
        count = (IDX_W+1)'(256);
    end
    last = big_blocks ? IDX_W'(255) : IDX_W'(1023);
    if (count == '0)
      hit = 1'b0;
    else if (top_bottom_select)
      hit = ({1'b0, blk_idx} < count);
    else
      // one bit wider so a full-array count cannot wrap
      hit = (({1'b0, blk_idx} + count) > {1'b0, last});
  end
endmodule // fbwp_range

// ### core/fbwp_top.sv
// Purpose: write protection of a serial flash behind an AHB-Lite slave
// Assumes: one master, single word transfers, always OKAY response
// Notes: commands written to CMD act at once; RESULT shows the outcome
`timescale 1ns/1ps
`include "fbwp_defs.svh"
// Operation
// - block program/erase inside protected range
// - full erase only when level zero
// - lock plus low wp drops status writes
// - otherwise status writes update bits
// - quad enable turns pins to data
// - small blocks level 1..10 powers of two
// - small blocks levels 11..15 upper counts
// - top/bottom select anchors protected range
// - large blocks levels 1..8 powers
// - large blocks levels 9..15 protect all
// - volatile writes need no write enable
// - write enable sets latch before writes
// - protection bits start at zero
module fbwp_top
  import fbwp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wp_io2_in,
  output logic wp_io2_out,
  output logic wp_io2_oe,
  input wire logic hold_io3_in,
  output logic hold_io3_out,
  output logic hold_io3_oe,
  input wire logic quad_drive,
  input wire logic [1:0] quad_data,
  output logic wp_active_n,
  output logic hold_active_n,
  output logic program_start,
  output logic erase_start
);
  fbwp_regs_t r;
  fbwp_regs_t nxt;
  logic [9:0] blk_idx;
  logic hit;
  logic take;
  logic [3:0] level;
  logic wp_low;
  logic sr_locked;
  logic is_pe;
  logic prog_p_r;
  logic erase_p_r;
  logic prog_p_nxt;
  logic erase_p_nxt;

  assign level = r.status_sr[`FBWP_ST_BP_LO+3:`FBWP_ST_BP_LO];
  assign wp_low = ~r.status_sr[`FBWP_ST_QE] & ~wp_io2_in;
  assign sr_locked = r.status_sr[`FBWP_ST_LOCK] & wp_low;
  // data lines driven only in quad mode
  // quad off keeps pins input only
  assign wp_io2_oe = r.status_sr[`FBWP_ST_QE] & quad_drive;
  assign hold_io3_oe = r.status_sr[`FBWP_ST_QE] & quad_drive;
  assign wp_io2_out = quad_data[0];
  assign hold_io3_out = quad_data[1];
  assign wp_active_n = r.status_sr[`FBWP_ST_QE] | wp_io2_in;
  assign hold_active_n = r.status_sr[`FBWP_ST_QE] | hold_io3_in;

  assign blk_idx = r.big_blocks ?
    {2'b00, r.addr[`FBWP_BLK256_LSB+7:`FBWP_BLK256_LSB]} :
    r.addr[`FBWP_BLK64_LSB+9:`FBWP_BLK64_LSB];

  fbwp_range #(.IDX_W(10)) u_range (
    .level(level),
    .top_bottom_select(r.top_bottom_select),
    .big_blocks(r.big_blocks),
    .blk_idx(blk_idx),
    .hit(hit)
  );

  function automatic logic [31:0] rd_mux(input fbwp_regs_t s,
                                         input logic [4:0] a);
    logic [31:0] v;
    v = 32'h0;
    unique case ({1'b0, a, 2'b00})
      `FBWP_OFF_STATUS: v = {24'h0, s.status_sr};
      `FBWP_OFF_CMD: v = {24'h0, s.cmd};
      `FBWP_OFF_ADDR: v = {6'h0, s.addr};
      `FBWP_OFF_RESULT: v = {29'h0, s.result};
      `FBWP_OFF_CONFIG: v = {30'h0, s.big_blocks, s.top_bottom_select};
      `FBWP_OFF_VOLREG: v = {16'h0, s.volreg1, s.volreg0};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  assign take = hsel & hready & htrans[1];
  assign is_pe = (r.cmd == `FBWP_OP_PP) | (r.cmd == `FBWP_OP_SER) |
                 (r.cmd == `FBWP_OP_BER);

  always_comb begin
    nxt = r;
    prog_p_nxt = 1'b0;
    erase_p_nxt = 1'b0;
    unique case (r.state)
      FBWP_IDLE: begin
        if (take) begin
          nxt.haddr = haddr[6:2];
          nxt.hwrite = hwrite;
          nxt.state = FBWP_DATA;
          // read data is registered here so it stands in the data phase
          if (!hwrite)
            nxt.hrdata = rd_mux(r, haddr[6:2]);
        end
      end
      FBWP_DATA: begin
        nxt.state = FBWP_IDLE;
        if (r.hwrite) begin
          if ({r.haddr, 2'b00} == 7'(`FBWP_OFF_ADDR))
            nxt.addr = hwdata[25:0];
          if ({r.haddr, 2'b00} == 7'(`FBWP_OFF_CONFIG)) begin
            // top/bottom is one-way: once bottom, stays bottom
            nxt.top_bottom_select = r.top_bottom_select | hwdata[0];
            nxt.big_blocks = hwdata[1];
          end
          if ({r.haddr, 2'b00} == 7'(`FBWP_OFF_CMD)) begin
            nxt.cmd = hwdata[7:0];
            nxt.state = FBWP_RESP;
          end
        end
      end
      FBWP_RESP: begin
        // result: 0 done, 1 no write enable, 2 protected, 3 locked, 4 unknown command
        nxt.state = FBWP_IDLE;
        nxt.result = 3'h0;
        unique case (r.cmd)
          `FBWP_OP_WRITE_ENABLE_CMD: nxt.status_sr[`FBWP_ST_WEL] = 1'b1;
          `FBWP_OP_WRDI: nxt.status_sr[`FBWP_ST_WEL] = 1'b0;
          `FBWP_OP_VOLATILE_READ_PARAM_WRITE_CMD: nxt.volreg0 = r.addr[7:0];
          `FBWP_OP_VOLATILE_BANK_WRITE_CMD: nxt.volreg1 = r.addr[7:0];
          `FBWP_OP_STATUS_WRITE_CMD: begin
            if (!r.status_sr[`FBWP_ST_WEL])
              nxt.result = 3'h1;
            else if (sr_locked)
              nxt.result = 3'h3;
            else
              nxt.status_sr = {r.addr[7:2], 2'b00};
            nxt.status_sr[`FBWP_ST_WEL] = 1'b0;
          end
          `FBWP_OP_CER1, `FBWP_OP_CER2: begin
            if (!r.status_sr[`FBWP_ST_WEL])
              nxt.result = 3'h1;
            else if (level != 4'h0)
              nxt.result = 3'h2;
            else
              erase_p_nxt = 1'b1;
            nxt.status_sr[`FBWP_ST_WEL] = 1'b0;
          end
          default: begin
            if (is_pe) begin
              if (!r.status_sr[`FBWP_ST_WEL])
                nxt.result = 3'h1;
              else if (hit)
                nxt.result = 3'h2;
              else begin
                prog_p_nxt = (r.cmd == `FBWP_OP_PP);
                erase_p_nxt = (r.cmd != `FBWP_OP_PP);
              end
              nxt.status_sr[`FBWP_ST_WEL] = 1'b0;
            end else begin
              nxt.result = 3'h4;
            end
          end
        endcase
      end
      default: nxt.state = FBWP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{status_sr: `FBWP_STATUS_RST, state: FBWP_IDLE, default: '0};
      prog_p_r <= 1'b0;
      erase_p_r <= 1'b0;
    end else begin
      r <= nxt;
      prog_p_r <= prog_p_nxt;
      erase_p_r <= erase_p_nxt;
    end
  end

  assign hrdata = r.hrdata;
  // the command slot costs one extra wait cycle so RESULT is settled
  assign hreadyout = (r.state != FBWP_DATA) ||
                     !(r.hwrite && {r.haddr, 2'b00} == 7'(`FBWP_OFF_CMD));
  assign hresp = 1'b0;
  assign program_start = prog_p_r;
  assign erase_start = erase_p_r;

  // no chip erase at nonzero level
  a_chip_erase_gate: assert property (@(posedge clk) disable iff (sys_rst)
    erase_start && $past(r.cmd == `FBWP_OP_CER1 || r.cmd == `FBWP_OP_CER2)
    |-> $past(level) == 4'h0)
    else $error("chip erase with protection set");
  a_protect_block: assert property (@(posedge clk) disable iff (sys_rst)
    (r.state == FBWP_RESP && hit && is_pe) |=> !program_start && !erase_start)
    else $error("protected block started");
  a_lock_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (r.state == FBWP_RESP && r.cmd == `FBWP_OP_STATUS_WRITE_CMD && sr_locked)
    |=> r.status_sr[7:2] == $past(r.status_sr[7:2]))
    else $error("locked status changed");
  a_status_write: assert property (@(posedge clk) disable iff (sys_rst)
    (r.state == FBWP_RESP && r.cmd == `FBWP_OP_STATUS_WRITE_CMD && !sr_locked &&
     r.status_sr[`FBWP_ST_WEL]) |=> r.status_sr[7:2] == $past(r.addr[7:2]))
    else $error("status write lost");
  a_pin_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (wp_io2_oe || hold_io3_oe) |-> r.status_sr[`FBWP_ST_QE])
    else $error("pins driven with quad off");
  a_wel_set: assert property (@(posedge clk) disable iff (sys_rst)
    (r.state == FBWP_RESP && r.cmd == `FBWP_OP_WRITE_ENABLE_CMD)
    |=> r.status_sr[`FBWP_ST_WEL])
    else $error("write enable not latched");
  a_vol_write: assert property (@(posedge clk) disable iff (sys_rst)
    (r.state == FBWP_RESP && r.cmd == `FBWP_OP_VOLATILE_READ_PARAM_WRITE_CMD)
    |=> r.volreg0 == $past(r.addr[7:0]))
    else $error("volatile write not taken");
  a_bottom_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (r.top_bottom_select && level != 4'h0 && blk_idx == 10'h0) |-> hit)
    else $error("bottom range misses block zero");
endmodule // fbwp_top

// ### dv/fbwp_pins.sv
// Purpose: board wiring of the two shared pins as the host sees them
// Assumes: host levels come from the bench
// Notes: no pull-ups; a pin the device does not drive reads the host level
`timescale 1ns/1ps
module fbwp_pins (
  input wire logic wp_drive,
  input wire logic hold_drive,
  input wire logic wp_io2_out,
  input wire logic wp_io2_oe,
  input wire logic hold_io3_out,
  input wire logic hold_io3_oe,
  output logic wp_io2_in,
  output logic hold_io3_in
);
  // host lets go of the pins
  // host releases a pin whenever the device drives it, so no fight
  assign wp_io2_in = wp_io2_oe ? wp_io2_out : wp_drive;
  assign hold_io3_in = hold_io3_oe ? hold_io3_out : hold_drive;
endmodule // fbwp_pins

// ### dv/fbwp_top_bench.sv
// Purpose: self-checking bench for the block write protect slave
// Assumes: single AHB-Lite master, whole words only
// Notes: expectations come from the protected block counts
`timescale 1ns/1ps
`include "fbwp_defs.svh"
module fbwp_top_bench;
  import fbwp_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, quad_drive = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0, quad_data = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, wp_lvl = 1, hd_lvl = 1, wp_in, wp_out, wp_oe;
  logic hd_in, hd_out, hd_oe, wp_act_n, hd_act_n, pgm, ers;
  int failures = 0, checked = 0, pcnt = 0, ecnt = 0, ep = 0, ee = 0;
  int n, tot, pb, ob;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    pcnt += (pgm === 1'b1);
    ecnt += (ers === 1'b1);
  end
  fbwp_top dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wp_io2_in(wp_in),
    .wp_io2_out(wp_out), .wp_io2_oe(wp_oe), .hold_io3_in(hd_in),
    .hold_io3_out(hd_out), .hold_io3_oe(hd_oe), .quad_drive(quad_drive),
    .quad_data(quad_data), .wp_active_n(wp_act_n),
    .hold_active_n(hd_act_n), .program_start(pgm), .erase_start(ers));
  fbwp_pins pins_u (.wp_drive(wp_lvl), .hold_drive(hd_lvl),
    .wp_io2_out(wp_out), .wp_io2_oe(wp_oe), .hold_io3_out(hd_out),
    .hold_io3_oe(hd_oe), .wp_io2_in(wp_in), .hold_io3_in(hd_in));
  task automatic summarize();
    if (failures == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input string nm, input logic [31:0] a,
                       input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] a);
    ahb(1'b1, `FBWP_OFF_ADDR, a);
    ahb(1'b1, `FBWP_OFF_CMD, {24'h0, op});
  endtask
  task automatic setsr(input logic [7:0] v);
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 32'h0);
    cmd(`FBWP_OP_STATUS_WRITE_CMD, {24'h0, v});
  endtask
  // program on even levels, block erase on odd, so both paths are hit
  task automatic try(input int blk, input logic big, input int lv,
                     input logic [31:0] e);
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 32'h0);
    cmd(lv[0] ? `FBWP_OP_BER : `FBWP_OP_PP, blk << (big ? 18 : 16));
    rdchk("result", `FBWP_OFF_RESULT, e);
    if (e == 0 && lv[0]) ee++;
    if (e == 0 && !lv[0]) ep++;
  endtask
  function automatic int nprot(input int lv, input logic big);
    int t[5] = '{768, 896, 960, 992, 1024};
    if (lv == 0) return 0;
    if (big) return (lv >= 9) ? 256 : (1 << (lv - 1));
    return (lv <= 10) ? (1 << (lv - 1)) : t[lv - 11];
  endfunction
  initial begin
    #(25 * 40000);
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdchk("status at reset", `FBWP_OFF_STATUS, 32'h0);
    ahb(1'b1, 32'h1c, 32'hffff_ffff);
    rdchk("unmapped", 32'h1c, 32'h0);
    cmd(`FBWP_OP_PP, 32'h0);
    rdchk("no write enable", `FBWP_OFF_RESULT, 32'h1);
    cmd(`FBWP_OP_VOLATILE_READ_PARAM_WRITE_CMD, 32'h5a);
    cmd(`FBWP_OP_VOLATILE_BANK_WRITE_CMD, 32'h3c);
    rdchk("volatile regs", `FBWP_OFF_VOLREG, 32'h3c5a);
    // tbs is sticky, so the top half of the sweep must run first
    for (int tb = 0; tb < 2; tb++) begin
      for (int bg = 0; bg < 2; bg++) begin
        ahb(1'b1, `FBWP_OFF_CONFIG, {30'h0, bg[0], tb[0]});
        tot = bg ? 256 : 1024;
        for (int lv = 0; lv < 16; lv++) begin
          setsr(8'(lv << 2));
          rdchk("status level", `FBWP_OFF_STATUS, lv << 2);
          n = nprot(lv, bg[0]);
          pb = tb ? n - 1 : tot - n;
          ob = tb ? n : tot - n - 1;
          if (n > 0) try(pb, bg[0], lv, 32'h2);
          if (n < tot) try(ob, bg[0], lv, 32'h0);
        end
      end
    end
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 32'h0);
    cmd(`FBWP_OP_CER1, 32'h0);
    rdchk("full erase refused", `FBWP_OFF_RESULT, 32'h2);
    setsr(8'h00);
    cmd(`FBWP_OP_WRITE_ENABLE_CMD, 32'h0);
    cmd(`FBWP_OP_CER2, 32'h0);
    rdchk("full erase taken", `FBWP_OFF_RESULT, 32'h0);
    ee++;
    repeat (2) @(posedge clk);
    chk("program pulses", ep, pcnt);
    chk("erase pulses", ee, ecnt);
    wp_lvl <= 1'b0;
    repeat (2) @(posedge clk);
    chk("wp active", 32'h0, {31'h0, wp_act_n});
    wp_lvl <= 1'b1;
    setsr(8'h84);
    wp_lvl <= 1'b0;
    setsr(8'h00);
    rdchk("locked result", `FBWP_OFF_RESULT, 32'h3);
    rdchk("locked status", `FBWP_OFF_STATUS, 32'h84);
    wp_lvl <= 1'b1;
    setsr(8'h40);
    rdchk("unlocked status", `FBWP_OFF_STATUS, 32'h40);
    quad_drive <= 1'b1;
    quad_data <= 2'b10;
    repeat (2) @(posedge clk);
    chk("quad pins", 32'h1d, {wp_oe, hd_oe, hd_in, wp_in, wp_act_n});
    summarize();
  end
endmodule // fbwp_top_bench
